// *** hdl/osw_clock_ctrl.v ***
// clock source controller: register slave, source switch, pin control, stop gating
// assumes all pins synchronous to hclk; clocks leave as one-cycle enable pulses
//
// Overview of operation
// - each option register takes one write per reset, later writes ignored
// - option registers sit at 0x1E and 0x1F and always read back
// - reset loads fixed defaults, all zero, into option registers
// - a programmed external option enables input pin, plus output for crystal
// - after go, two external rising edges are counted before switching
// - switch glitch-free, set engaged status, then stop internal oscillator
// - option and go both cleared returns to the internal source
// - external clock mode: input is fast clock, halved for half-rate clock
// - external clock mode forces clock output enable clear
// - crystal mode owns the output pin, clock output enable ignored
// - internal or RC: enable drives fast clock out, else port pin
// - stop clears the integration counter and gates the fast clock, and the half-rate clock unless oscillator-in-stop
// - oscillator-in-stop keeps the half-rate clock running in stop
// - recovery is 32 fast cycles with short select, else 4096
// - interrupt, reset or break ends stop; stacking waits for recovery
// - internal frequency field picks 1, 2 or 3.2 MHz
// - external range field picks low, medium or high crystal range
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
`include "osw_regs.vh"
module osw_clock_ctrl #(
	parameter REC_LONG  = `OSW_REC_LONG,
	parameter REC_SHORT = `OSW_REC_SHORT
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire        clock_input_pin,
	output wire        clock_input_enable,
	output reg         clock_output_pin_o,
	output reg         clock_output_pin_oe,
	output wire        port_a_bit4_io_sel,
	output wire [1:0]  external_range_select,
	output wire        internal_osc_on,
	output reg         fast_system_clock,
	output reg         half_rate_system_clock,
	input  wire        stop_enter,
	input  wire        wake_irq,
	input  wire        wake_break,
	output wire        stop_active,
	output wire        sim_counter_clear,
	output wire        stacking_go
);
	localparam ST_INT    = 2'h0;
	localparam ST_CHECK  = 2'h1;
	localparam ST_SWITCH = 2'h2;
	localparam ST_EXT    = 2'h3;
	localparam DIV_1M  = `OSW_HCLK_KHZ / `OSW_FAST_1MHZ_KHZ;
	localparam DIV_2M  = `OSW_HCLK_KHZ / `OSW_FAST_2MHZ_KHZ;
	localparam DIV_3M2 = `OSW_HCLK_KHZ / `OSW_FAST_3M2_KHZ;
	localparam [7:0] RST_OSC = `OSW_RST_OSC_CTRL;
	localparam [7:0] RST_PIN = `OSW_RST_PIN_CTRL;

	// register storage
	reg [7:0] opt_low_reg;
	reg [7:0] opt_high_reg;
	reg       low_locked_reg;
	reg       high_locked_reg;
	reg [1:0] ext_opt_reg;
	reg [1:0] int_frq_reg;
	reg [1:0] ext_rng_reg;
	reg       go_reg;
	reg       engaged_reg;
	reg       clk_out_en_reg;

	// bus pipeline
	reg       wr_pend_reg;
	reg       rd_pend_reg;
	reg [7:0] addr_reg;

	// switch state and clocks
	reg [1:0] state_reg;
	reg       osc_off_reg;
	reg [4:0] div_cnt_reg;
	reg       ext_q_reg;
	reg       ext_prev_reg;
	reg       half_phase_reg;
	reg       out_toggle_reg;

	wire       take;
	wire       ext_rise;
	wire       int_tick;
	wire       fast_tick;
	wire       half_tick;
	wire       seen_two;
	wire       in_stop;
	wire [4:0] div_len;

	// fast-clock divisor for the chosen internal frequency
	function [4:0] frq_div;
		input [1:0] sel;
		begin
			case (sel)
				`OSW_FRQ_1MHZ:  frq_div = DIV_1M[4:0];
				`OSW_FRQ_2MHZ:  frq_div = DIV_2M[4:0];
				`OSW_FRQ_3M2HZ: frq_div = DIV_3M2[4:0];
				default:        frq_div = DIV_3M2[4:0];
			endcase
		end
	endfunction

	// address decode shared by read and write
	function [2:0] reg_sel;
		input [7:0] a;
		begin
			case (a)
				`OSW_ADDR_OPT_LOW:  reg_sel = 3'h1;
				`OSW_ADDR_OPT_HIGH: reg_sel = 3'h2;
				`OSW_ADDR_OSC_CTRL: reg_sel = 3'h3;
				`OSW_ADDR_PIN_CTRL: reg_sel = 3'h4;
				default:            reg_sel = 3'h0;
			endcase
		end
	endfunction

	// reads take one wait state so a write just before is visible
	assign hreadyout = ~rd_pend_reg;
	assign hresp     = 1'b0;
	assign take      = hsel && hready && htrans[1];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
		end else begin
			if (hready) begin
				wr_pend_reg <= take && hwrite;
				rd_pend_reg <= take && !hwrite;
				if (take) begin
					addr_reg <= haddr[7:0];
				end
			end else begin
				rd_pend_reg <= 1'b0;
			end
		end
	end

	// read data, unmapped reads give zero
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_pend_reg) begin
			case (reg_sel(addr_reg))
				3'h1: hrdata <= {24'h000000, opt_low_reg};
				3'h2: hrdata <= {24'h000000, opt_high_reg};
				3'h3: hrdata <= {24'h000000, ext_opt_reg, int_frq_reg, ext_rng_reg, go_reg, engaged_reg};
				3'h4: hrdata <= {31'h00000000, clk_out_en_reg};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// once-writable option registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opt_low_reg     <= `OSW_RST_OPT_LOW;
			opt_high_reg    <= `OSW_RST_OPT_HIGH;
			low_locked_reg  <= 1'b0;
			high_locked_reg <= 1'b0;
		end else if (wr_pend_reg) begin
			if (reg_sel(addr_reg) == 3'h1 && !low_locked_reg) begin
				opt_low_reg    <= hwdata[7:0];
				low_locked_reg <= 1'b1;
			end
			if (reg_sel(addr_reg) == 3'h2 && !high_locked_reg) begin
				opt_high_reg    <= hwdata[7:0];
				high_locked_reg <= 1'b1;
			end
		end
	end

	// oscillator control and pin control, rewritable; pin control held clear in external clock mode
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_opt_reg    <= RST_OSC[`OSW_EXT_OPT_HI:`OSW_EXT_OPT_LO];
			int_frq_reg    <= RST_OSC[`OSW_INT_FRQ_HI:`OSW_INT_FRQ_LO];
			ext_rng_reg    <= RST_OSC[`OSW_EXT_RNG_HI:`OSW_EXT_RNG_LO];
			go_reg         <= RST_OSC[`OSW_BIT_GO];
			clk_out_en_reg <= RST_PIN[`OSW_BIT_CLK_OUT];
		end else begin
			if (wr_pend_reg && reg_sel(addr_reg) == 3'h3) begin
				ext_opt_reg <= hwdata[`OSW_EXT_OPT_HI:`OSW_EXT_OPT_LO];
				int_frq_reg <= hwdata[`OSW_INT_FRQ_HI:`OSW_INT_FRQ_LO];
				ext_rng_reg <= hwdata[`OSW_EXT_RNG_HI:`OSW_EXT_RNG_LO];
				go_reg      <= hwdata[`OSW_BIT_GO];
			end
			if (ext_opt_reg == `OSW_OPT_EXT_CLK) begin
				clk_out_en_reg <= 1'b0;
			end else if (wr_pend_reg && reg_sel(addr_reg) == 3'h4) begin
				clk_out_en_reg <= hwdata[`OSW_BIT_CLK_OUT];
			end
		end
	end

	assign external_range_select = ext_rng_reg;
	assign clock_input_enable    = ext_opt_reg != `OSW_OPT_INTERNAL;

	// external pin sampling and edge detection
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_q_reg    <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else begin
			ext_q_reg    <= clock_input_pin;
			ext_prev_reg <= ext_q_reg;
		end
	end
	assign ext_rise = clock_input_enable && ext_q_reg && !ext_prev_reg;

	osw_edge_check #(
		.EDGES(`OSW_EDGES_NEEDED)
	) u_edge (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.arm        (state_reg == ST_CHECK),
		.ext_rise   (ext_rise),
		.active_seen(seen_two)
	);

	// source switch sequence
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg   <= ST_INT;
			engaged_reg <= 1'b0;
			osc_off_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_INT: begin
					if (go_reg && ext_opt_reg != `OSW_OPT_INTERNAL) begin
						state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (!go_reg) begin
						state_reg <= ST_INT;
					end else if (seen_two) begin
						state_reg <= ST_SWITCH;
					end
				end
				// hand over just after an external edge so no short period slips out
				ST_SWITCH: begin
					if (!go_reg) begin
						state_reg <= ST_INT;
					end else if (ext_rise) begin
						engaged_reg <= 1'b1;
						state_reg   <= ST_EXT;
					end
				end
				ST_EXT: begin
					osc_off_reg <= 1'b1;
					if (!go_reg && ext_opt_reg == `OSW_OPT_INTERNAL) begin
						engaged_reg <= 1'b0;
						osc_off_reg <= 1'b0;
						state_reg   <= ST_INT;
					end
				end
				default: state_reg <= ST_INT;
			endcase
		end
	end
	assign internal_osc_on = ~osc_off_reg;

	// internal oscillator model as an enable divider
	assign div_len = frq_div(int_frq_reg);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_reg <= 5'h00;
		end else if (osc_off_reg || div_cnt_reg >= div_len - 5'h01) begin
			div_cnt_reg <= 5'h00;
		end else begin
			div_cnt_reg <= div_cnt_reg + 5'h01;
		end
	end
	assign int_tick = !osc_off_reg && div_cnt_reg == div_len - 5'h01;

	// engaged external source feeds the fast clock directly
	assign fast_tick = engaged_reg ? ext_rise : int_tick;
	assign half_tick = fast_tick && half_phase_reg;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_phase_reg <= 1'b0;
			out_toggle_reg <= 1'b0;
		end else if (fast_tick) begin
			half_phase_reg <= ~half_phase_reg;
			out_toggle_reg <= ~out_toggle_reg;
		end
	end

	osw_stop_ctrl #(
		.REC_LONG (REC_LONG),
		.REC_SHORT(REC_SHORT)
	) u_stop (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.stop_enter(stop_enter),
		.wake      (wake_irq || wake_break),
		.short_sel (opt_high_reg[`OSW_BIT_SHORT_REC]),
		.fast_tick (fast_tick),
		.in_stop   (in_stop),
		.sim_clear (sim_counter_clear),
		.stack_go  (stacking_go)
	);
	assign stop_active = in_stop;

	// gated system clock enables
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_system_clock      <= 1'b0;
			half_rate_system_clock <= 1'b0;
		end else begin
			fast_system_clock      <= fast_tick && !in_stop;
			half_rate_system_clock <= half_tick && (!in_stop || opt_low_reg[`OSW_BIT_OSC_IN_STOP]);
		end
	end

	// clock output pin function
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_output_pin_o  <= 1'b0;
			clock_output_pin_oe <= 1'b0;
		end else begin
			case (ext_opt_reg)
				`OSW_OPT_XTAL: begin
					clock_output_pin_o  <= ~ext_q_reg;
					clock_output_pin_oe <= 1'b1;
				end
				`OSW_OPT_EXT_CLK: begin
					clock_output_pin_o  <= 1'b0;
					clock_output_pin_oe <= 1'b0;
				end
				default: begin
					clock_output_pin_o  <= clk_out_en_reg & out_toggle_reg;
					clock_output_pin_oe <= clk_out_en_reg;
				end
			endcase
		end
	end
	// pin free for port use whenever the clock path does not own it
	assign port_a_bit4_io_sel = (ext_opt_reg != `OSW_OPT_XTAL) && !clk_out_en_reg;
endmodule

// *** pkg/osw_regs.vh ***
// register map, field layout, reset values and timing for the clock source switch
// assumes a 100 MHz hclk and word-aligned AHB-Lite access
`ifndef OSW_REGS_VH
`define OSW_REGS_VH
// register indices and their byte addresses (index times four)
`define OSW_IDX_OPT_LOW   8'h1E
`define OSW_IDX_OPT_HIGH  8'h1F
`define OSW_IDX_OSC_CTRL  8'h36
`define OSW_IDX_PIN_CTRL  8'h0C
`define OSW_ADDR_OPT_LOW  8'h78
`define OSW_ADDR_OPT_HIGH 8'h7C
`define OSW_ADDR_OSC_CTRL 8'hD8
`define OSW_ADDR_PIN_CTRL 8'h30
// reset values
`define OSW_RST_OPT_LOW   8'h00
`define OSW_RST_OPT_HIGH  8'h00
`define OSW_RST_OSC_CTRL  8'h20
`define OSW_RST_PIN_CTRL  8'h00
// option register fields
`define OSW_BIT_OSC_IN_STOP 1
`define OSW_BIT_SHORT_REC   1
// oscillator control fields
`define OSW_EXT_OPT_HI  7
`define OSW_EXT_OPT_LO  6
`define OSW_INT_FRQ_HI  5
`define OSW_INT_FRQ_LO  4
`define OSW_EXT_RNG_HI  3
`define OSW_EXT_RNG_LO  2
`define OSW_BIT_GO      1
`define OSW_BIT_ENGAGED 0
`define OSW_BIT_CLK_OUT 0
// external option encodings
`define OSW_OPT_INTERNAL 2'h0
`define OSW_OPT_EXT_CLK  2'h1
`define OSW_OPT_RC       2'h2
`define OSW_OPT_XTAL     2'h3
// internal frequency encodings
`define OSW_FRQ_1MHZ  2'h0
`define OSW_FRQ_2MHZ  2'h1
`define OSW_FRQ_3M2HZ 2'h2
// fast clock is four times the bus rate: 4, 8 and 12.8 MHz at 100 MHz hclk
`define OSW_HCLK_KHZ      100000
`define OSW_FAST_1MHZ_KHZ 4000
`define OSW_FAST_2MHZ_KHZ 8000
`define OSW_FAST_3M2_KHZ  12800
`define OSW_EDGES_NEEDED  2
`define OSW_REC_LONG      4096
`define OSW_REC_SHORT     32
`endif

// *** hdl/osw_edge_check.v ***
// counts external rising edges while a switch-over is armed
// assumes ext_rise is a one-cycle pulse synchronous to hclk
`timescale 1ns/10ps
`include "osw_regs.vh"
module osw_edge_check #(
	parameter EDGES = `OSW_EDGES_NEEDED
) (
	input  wire hclk,
	input  wire hresetn,
	input  wire arm,
	input  wire ext_rise,
	output wire active_seen
);
	reg [3:0] edge_cnt_reg;
	// a dead source leaves the count short and the switch waiting
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_cnt_reg <= 4'h0;
		end else if (!arm) begin
			edge_cnt_reg <= 4'h0;
		end else if (ext_rise && edge_cnt_reg < EDGES[3:0]) begin
			edge_cnt_reg <= edge_cnt_reg + 4'h1;
		end
	end
	assign active_seen = arm && (edge_cnt_reg >= EDGES[3:0]);
endmodule

// *** hdl/osw_stop_ctrl.v ***
// stop mode sequencing and recovery delay counter
// assumes fast_tick is the ungated fast clock enable pulse
`timescale 1ns/10ps
`include "osw_regs.vh"
module osw_stop_ctrl #(
	parameter REC_LONG  = `OSW_REC_LONG,
	parameter REC_SHORT = `OSW_REC_SHORT
) (
	input  wire hclk,
	input  wire hresetn,
	input  wire stop_enter,
	input  wire wake,
	input  wire short_sel,
	input  wire fast_tick,
	output reg  in_stop,
	output reg  sim_clear,
	output reg  stack_go
);
	reg        recovering_reg;
	reg [12:0] rec_cnt_reg;
	wire [12:0] rec_len = short_sel ? REC_SHORT[12:0] : REC_LONG[12:0];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_stop        <= 1'b0;
			sim_clear      <= 1'b0;
			stack_go       <= 1'b0;
			recovering_reg <= 1'b0;
			rec_cnt_reg    <= 13'h0000;
		end else begin
			sim_clear <= 1'b0;
			stack_go  <= 1'b0;
			if (stop_enter && !in_stop) begin
				in_stop   <= 1'b1;
				sim_clear <= 1'b1;
			end else if (in_stop && !recovering_reg && wake) begin
				recovering_reg <= 1'b1;
				rec_cnt_reg    <= 13'h0000;
			end else if (recovering_reg && fast_tick) begin
				if (rec_cnt_reg == rec_len - 13'h0001) begin
					recovering_reg <= 1'b0;
					in_stop        <= 1'b0;
					stack_go       <= 1'b1;
				end else begin
					rec_cnt_reg <= rec_cnt_reg + 13'h0001;
				end
			end
		end
	end
endmodule

// *** bench/osw_clock_asserts.sv ***
// timing checks on the clock source controller ports
// assumes a single hclk domain and active-low hresetn
`timescale 1ns/10ps
module osw_clock_asserts (
	input wire       hclk,
	input wire       hresetn,
	input wire       hsel,
	input wire [1:0] htrans,
	input wire       hwrite,
	input wire       hready,
	input wire       hreadyout,
	input wire       hresp,
	input wire       clock_input_enable,
	input wire       internal_osc_on,
	input wire       fast_system_clock,
	input wire       half_rate_system_clock,
	input wire       stop_enter,
	input wire       stop_active,
	input wire       sim_counter_clear,
	input wire       stacking_go
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd_req;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_rd_ans;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence s_stop_req;
		stop_enter && !stop_active;
	endsequence
	sequence s_stop_in;
		stop_active && sim_counter_clear ##1 !sim_counter_clear;
	endsequence
	a_read_one_wait: assert property (s_rd_req |=> s_rd_ans)
		else $error("read wait state wrong");
	a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_stop_entry: assert property (s_stop_req |=> s_stop_in)
		else $error("stop entry wrong");
	a_stop_gated: assert property (stop_active && $past(stop_active) |-> !fast_system_clock)
		else $error("fast clock ran in stop");
	a_stack_after: assert property (stacking_go |-> $past(stop_active))
		else $error("stacking outside stop");
	a_stack_ends: assert property (stacking_go |-> ##[0:1] !stop_active)
		else $error("stop held after stacking");
	a_osc_off_ext: assert property ($fell(internal_osc_on) |-> clock_input_enable)
		else $error("internal oscillator stopped without external");
	// the tick on the recovery edge was gated with stop still set
	a_half_follows: assert property (half_rate_system_clock && !stop_active && !$past(stop_active) |-> fast_system_clock)
		else $error("half clock off fast tick");
endmodule
bind osw_clock_ctrl osw_clock_asserts osw_clock_asserts_inst (.*);

// *** bench/osw_ext_source.sv ***
// external clock source model feeding the clock input pin
// assumes run is driven from hclk; a stopped source holds its level
`timescale 1ns/10ps
module osw_ext_source #(
	parameter HALF = 5
) (
	input wire hclk,
	input wire run,
	output reg clk_out
);
	integer cnt;
	initial begin
		clk_out = 1'b0;
		cnt = 0;
	end
	// no edges until run, bench sets go first to check that a dead source leaves the switch waiting
	always @(posedge hclk) begin
		if (run) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				clk_out <= ~clk_out;
		end
	end
endmodule

// *** bench/osc_source_switch_stop_clock_bench.sv ***
// self-checking bench for the clock source controller
// assumes hready looped back from hreadyout, one slave
`timescale 1ns/10ps
`include "osw_regs.vh"
module osc_source_switch_stop_clock_bench;
	reg         hclk, hresetn, hwrite, stop_enter, wake_irq, wake_break, rd_dp, ext_run;
	reg  [31:0] haddr, hwdata, d;
	reg  [1:0]  htrans;
	reg  [31:0] exq[$];
	wire [31:0] hrdata;
	wire [1:0]  rng;
	wire        hreadyout, hresp, ext_clk, cie, pin_o, pin_oe, io_sel, osc_on, fclk, hclk2;
	wire        stop_act, sim_clr, stack_go;
	integer     n_fail, checked, seed, cyc, k, nf, nh;
	osw_ext_source osw_ext_source_inst (.hclk(hclk), .run(ext_run), .clk_out(ext_clk));
	osw_clock_ctrl #(.REC_LONG(64)) osw_clock_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clock_input_pin(ext_clk),
		.clock_input_enable(cie), .clock_output_pin_o(pin_o), .clock_output_pin_oe(pin_oe),
		.port_a_bit4_io_sel(io_sel), .external_range_select(rng), .internal_osc_on(osc_on),
		.fast_system_clock(fclk), .half_rate_system_clock(hclk2), .stop_enter(stop_enter),
		.wake_irq(wake_irq), .wake_break(wake_break), .stop_active(stop_act),
		.sim_counter_clear(sim_clr), .stacking_go(stack_go));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("mismatch at %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task complete_run;
		begin
			$display("checked %0d n_fail %0d", checked, n_fail);
			if (n_fail == 0 && checked > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// one transfer; a read notes its expected word for the monitor
	task bus(input [7:0] a, input w, input [31:0] v);
		begin
			@(posedge hclk);
			haddr <= {24'h000000, a};
			htrans <= 2'h2;
			hwrite <= w;
			@(posedge hclk);
			while (hreadyout !== 1'b1) @(posedge hclk);
			htrans <= 2'h0;
			hwdata <= v;
			rd_dp <= !w;
			if (!w)
				exq.push_back(v);
			@(posedge hclk);
			while (hreadyout !== 1'b1) @(posedge hclk);
			rd_dp <= 1'b0;
		end
	endtask
	task pulses(input integer c);
		begin
			nf = 0;
			nh = 0;
			repeat (c) begin
				@(posedge hclk);
				nf = nf + fclk;
				nh = nh + hclk2;
			end
		end
	endtask
	// recovery counted in hclk; a fast tick is 7 hclk at 3.2 MHz
	task stop_run(input integer n, input [31:0] half_on, input brk);
		begin
			@(posedge hclk);
			stop_enter <= 1'b1;
			@(posedge hclk);
			stop_enter <= 1'b0;
			// pulse launched on the entry edge is still ungated
			@(posedge hclk);
			pulses(40);
			chk(nf, 0);
			chk(nh > 0, half_on);
			wake_irq <= !brk;
			wake_break <= brk;
			@(posedge hclk);
			wake_irq <= 1'b0;
			wake_break <= 1'b0;
			k = 0;
			while (stack_go !== 1'b1 && k < 2000) begin
				@(posedge hclk);
				k = k + 1;
			end
			chk(k >= n * 7 - 8 && k <= n * 7 + 8, 1);
			$display("test stop recovery %0d done", n);
		end
	endtask
	always @(posedge hclk)
		if (rd_dp && hreadyout)
			chk(hrdata, exq.pop_front());
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			complete_run;
		end
	end
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		{hwrite, stop_enter, wake_irq, wake_break, rd_dp, ext_run} = 6'h00;
		{haddr, hwdata, d, htrans} = 0;
		{n_fail, checked, cyc} = 0;
		seed = 65;
		hresetn = 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(`OSW_ADDR_OPT_LOW, 0, 32'h00);
		bus(`OSW_ADDR_OPT_HIGH, 0, 32'h00);
		bus(`OSW_ADDR_OSC_CTRL, 0, 32'h20);
		bus(8'h04, 0, 32'h00);
		bus(`OSW_ADDR_OSC_CTRL, 1, 32'h21);
		bus(`OSW_ADDR_OSC_CTRL, 0, 32'h20);
		$display("test reset values done");
		bus(`OSW_ADDR_PIN_CTRL, 1, 32'h01);
		repeat (3) @(posedge hclk);
		chk({pin_oe, io_sel}, 2'b10);
		bus(`OSW_ADDR_PIN_CTRL, 1, 32'h00);
		repeat (3) @(posedge hclk);
		chk({pin_oe, io_sel}, 2'b01);
		bus(`OSW_ADDR_PIN_CTRL, 1, 32'h01);
		bus(`OSW_ADDR_OSC_CTRL, 1, 32'hAC);
		repeat (3) @(posedge hclk);
		chk({cie, rng, pin_oe}, 4'hF);
		bus(`OSW_ADDR_OSC_CTRL, 1, 32'hE0);
		bus(`OSW_ADDR_PIN_CTRL, 1, 32'h00);
		repeat (3) @(posedge hclk);
		chk({cie, pin_oe, io_sel}, 3'b110);
		chk(pin_o, 1);
		bus(`OSW_ADDR_PIN_CTRL, 1, 32'h01);
		bus(`OSW_ADDR_OSC_CTRL, 1, 32'h60);
		repeat (3) @(posedge hclk);
		chk({cie, pin_oe, io_sel}, 3'b101);
		repeat (100) @(posedge hclk);
		bus(`OSW_ADDR_OSC_CTRL, 1, 32'h62);
		repeat (60) @(posedge hclk);
		chk(osc_on, 1);
		bus(`OSW_ADDR_OSC_CTRL, 0, 32'h62);
		ext_run <= 1'b1;
		k = 0;
		while (osc_on !== 1'b0 && k < 300) begin
			@(posedge hclk);
			k = k + 1;
		end
		bus(`OSW_ADDR_OSC_CTRL, 0, 32'h63);
		pulses(200);
		chk(nf >= 19 && nf <= 21, 1);
		chk(nh >= 9 && nh <= 11, 1);
		bus(`OSW_ADDR_OSC_CTRL, 1, 32'h21);
		ext_run <= 1'b0;
		bus(`OSW_ADDR_OSC_CTRL, 0, 32'h20);
		repeat (3) @(posedge hclk);
		chk(osc_on, 1);
		$display("test source switch done");
		// fast clock is four times the bus rate: 25 and 12 hclk per tick
		bus(`OSW_ADDR_OSC_CTRL, 1, 32'h00);
		pulses(250);
		chk(nf >= 9 && nf <= 11, 1);
		bus(`OSW_ADDR_OSC_CTRL, 1, 32'h10);
		pulses(240);
		chk(nf >= 19 && nf <= 21, 1);
		bus(`OSW_ADDR_OSC_CTRL, 1, 32'h20);
		$display("test internal frequency done");
		stop_run(64, 0, 1'b1);
		d = $random(seed);
		bus(`OSW_ADDR_OPT_LOW, 1, 32'h02);
		bus(`OSW_ADDR_OPT_HIGH, 1, 32'h02);
		// bit 0 set so an ignored write always differs
		bus(`OSW_ADDR_OPT_LOW, 1, d | 32'h01);
		bus(`OSW_ADDR_OPT_HIGH, 1, ~d | 32'h01);
		bus(`OSW_ADDR_OPT_LOW, 0, 32'h02);
		bus(`OSW_ADDR_OPT_HIGH, 0, 32'h02);
		$display("test write once done");
		stop_run(32, 1, 1'b0);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(`OSW_ADDR_OPT_LOW, 0, 32'h00);
		bus(`OSW_ADDR_OPT_LOW, 1, 32'h02);
		bus(`OSW_ADDR_OPT_LOW, 0, 32'h02);
		$display("test second reset done");
		complete_run;
	end
endmodule
